// ==== verilog/pbdiv_top.sv ====
`timescale 1ns/1ps
`include "pbdiv_map.svh"

// Functional notes
// - Reference is divided by the selected table divisor, six and above.
// - Even divisor gives square output; odd adds one cycle to high time.
// - Rate clock is further divided by sixteen onto the 1X output.
// - Enable low forces rate clock and 1X output high.
// - Enable pin is pulled up, open means enabled.
// - Table holds thirty-two nineteen-bit divisors indexed by select word.
// - Select latch passes while gate high, holds while low.
// - With IMMEDIATE_CHANGE set, a new select starts the new frequency within 3.5 us.
// - Build option delays a new divisor to the end of the half-cycle.
// - Select bit 0 is least significant, bit 4 most significant.
// - Select inputs pulled up when open; gate input has no pull-up.
// - Two reference outputs: half rate and quarter rate.
module pbdiv_top
    import pbdiv_pkg::*;
#(
    parameter bit IMMEDIATE_CHANGE = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [`PBDIV_SEL_W-1:0] sel_pins,
    input wire logic [`PBDIV_SEL_W-1:0] sel_pins_open,
    input wire logic sel_latch_gate,
    input wire logic rate_output_enable_n,
    input wire logic rate_enable_open,
    output logic rate_clk_out,
    output logic baud_1x_out,
    output logic ref_clk_out,
    output logic ref_quarter_out
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Odd divisors put the spare cycle in the high half
    function automatic logic [`PBDIV_DIV_W-1:0] hi_len(
        input logic [`PBDIV_DIV_W-1:0] d
    );
        hi_len = d - (d >> 1);
    endfunction

    function automatic logic [`PBDIV_DIV_W-1:0] lo_len(
        input logic [`PBDIV_DIV_W-1:0] d
    );
        lo_len = d >> 1;
    endfunction

    // ------------------------------------------------------------------
    // Pin conditioning
    // ------------------------------------------------------------------
    wire logic [`PBDIV_SEL_W-1:0] sel_eff = sel_pins | sel_pins_open;
    wire logic en_eff = rate_output_enable_n | rate_enable_open;
    pbdiv_pins_t pins_raw;
    pbdiv_pins_t pins_s;

    // Gate has no pull-up, so it passes through untouched
    assign pins_raw.sel = sel_eff;
    assign pins_raw.gate = sel_latch_gate;
    assign pins_raw.en = en_eff;

    pbdiv_sync #(
        .W(`PBDIV_PIN_W),
        .RST_VAL(7'h7e)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .d(pins_raw),
        .q(pins_s)
    );

    // ------------------------------------------------------------------
    // Select latch
    // ------------------------------------------------------------------
    logic [`PBDIV_SEL_W-1:0] sel_latched;

    // Flop with enable stands in for a transparent latch
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sel_latched <= `PBDIV_SEL_RST;
        end else if (ce && pins_s.gate) begin
            sel_latched <= pins_s.sel;
        end
    end

    // ------------------------------------------------------------------
    // Divisor lookup
    // ------------------------------------------------------------------
    logic [`PBDIV_DIV_W-1:0] rom_div;

    pbdiv_rom u_rom (
        .clk(clk),
        .ce(ce),
        .addr(sel_latched),
        .data(rom_div)
    );

    // Entries below six would break the half-cycle arithmetic
    wire logic [`PBDIV_DIV_W-1:0] div_eff =
        (rom_div < `PBDIV_DIV_MIN) ? `PBDIV_DIV_MIN : rom_div;

    // ------------------------------------------------------------------
    // Rate divider
    // ------------------------------------------------------------------
    logic [`PBDIV_DIV_W-1:0] div_cur;
    logic [`PBDIV_DIV_W-1:0] cnt;
    pbdiv_phase_t phase;
    logic [`PBDIV_DIV_W-1:0] next_cnt;
    pbdiv_phase_t next_phase;

    wire logic chg = (div_eff != div_cur);
    wire logic end_half = (cnt == '0);
    wire logic take = chg && (IMMEDIATE_CHANGE || end_half);
    wire logic [`PBDIV_DIV_W-1:0] hi_new = hi_len(div_eff) - 19'h1;
    wire logic [`PBDIV_DIV_W-1:0] hi_cur = hi_len(div_cur) - 19'h1;
    wire logic [`PBDIV_DIV_W-1:0] lo_cur = lo_len(div_cur) - 19'h1;

    always_comb begin
        next_cnt = cnt - 19'h1;
        next_phase = phase;
        if (take) begin
            next_cnt = hi_new;
            next_phase = PBDIV_PH_HIGH;
        end else if (end_half) begin
            case (phase)
                PBDIV_PH_HIGH: begin
                    next_cnt = lo_cur;
                    next_phase = PBDIV_PH_LOW;
                end
                PBDIV_PH_LOW: begin
                    next_cnt = hi_cur;
                    next_phase = PBDIV_PH_HIGH;
                end
                default: begin
                    next_cnt = hi_cur;
                    next_phase = PBDIV_PH_HIGH;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_cur <= `PBDIV_DIV_RST;
            cnt <= '0;
            phase <= PBDIV_PH_HIGH;
        end else if (ce) begin
            if (take) begin
                div_cur <= div_eff;
            end
            cnt <= next_cnt;
            phase <= next_phase;
        end
    end

    // ------------------------------------------------------------------
    // Divide by sixteen
    // ------------------------------------------------------------------
    logic [`PBDIV_FO16_W-1:0] cnt16;
    wire logic fo_rise = (phase == PBDIV_PH_LOW) &&
        (next_phase == PBDIV_PH_HIGH);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt16 <= '0;
        end else if (ce && fo_rise) begin
            cnt16 <= cnt16 + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Reference outputs
    // ------------------------------------------------------------------
    // Registered outputs cannot reach clk itself; ref_clk_out is clk/2
    logic [`PBDIV_QTR_W-1:0] qcnt;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            qcnt <= '0;
            ref_clk_out <= 1'b0;
            ref_quarter_out <= 1'b0;
        end else if (ce) begin
            qcnt <= qcnt + 2'h1;
            ref_clk_out <= ~ref_clk_out;
            ref_quarter_out <= qcnt[1];
        end
    end

    // ------------------------------------------------------------------
    // Rate outputs
    // ------------------------------------------------------------------
    wire logic fo_gated = pins_s.en ? phase : 1'b1;
    wire logic f1x_gated = pins_s.en ? ~cnt16[3] : 1'b1;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rate_clk_out <= 1'b1;
            baud_1x_out <= 1'b1;
        end else if (ce) begin
            rate_clk_out <= fo_gated;
            baud_1x_out <= f1x_gated;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    localparam int SEL_DELAY_CYC = `PBDIV_SEL_DELAY_CYC;
    logic [7:0] sel_wait;

    // Cycles a latched select change has gone without taking effect
    always_ff @(posedge clk) begin
        if (!rst_n || !chg) begin
            sel_wait <= '0;
        end else if (ce && sel_wait != 8'hff) begin
            sel_wait <= sel_wait + 8'h1;
        end
    end

    AST_EN_FORCE: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && !pins_s.en |=> rate_clk_out && baud_1x_out
    ) else $error("rate outputs not held high while disabled");

    AST_HALF_LOW: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && end_half && !take && phase == PBDIV_PH_HIGH
        |=> phase == PBDIV_PH_LOW && cnt == $past(lo_cur)
    ) else $error("low half length wrong");

    AST_HALF_HIGH: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && end_half && !take && phase == PBDIV_PH_LOW
        |=> phase == PBDIV_PH_HIGH && cnt == $past(hi_cur)
    ) else $error("high half length wrong");

    AST_DIV_MIN: assert property (
        @(posedge clk) disable iff (!rst_n)
        div_cur == '0 || div_cur >= `PBDIV_DIV_MIN
    ) else $error("active divisor below minimum");

    AST_TAKE_RESTART: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && take |=> phase == PBDIV_PH_HIGH && cnt == $past(hi_new)
            && div_cur == $past(div_eff)
    ) else $error("new divisor did not restart high half");

    AST_DELAYED: assert property (
        @(posedge clk) disable iff (!rst_n)
        !IMMEDIATE_CHANGE && ce && chg && !end_half
        |=> div_cur == $past(div_cur)
    ) else $error("divisor changed mid half-cycle");

    AST_LATCH_HOLD: assert property (
        @(posedge clk) disable iff (!rst_n)
        !pins_s.gate |=> sel_latched == $past(sel_latched)
    ) else $error("select latch moved while gate low");

    AST_LATCH_PASS: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && pins_s.gate |=> sel_latched == $past(pins_s.sel)
    ) else $error("select latch not transparent");

    AST_SEL_IMMEDIATE: assert property (
        @(posedge clk) disable iff (!rst_n)
        IMMEDIATE_CHANGE && ce && $changed(sel_latched) ##1 ce ##1 ce
        |-> !chg
    ) else $error("new select not applied in two cycles");

    AST_SEL_BOUND: assert property (
        @(posedge clk) disable iff (!rst_n)
        IMMEDIATE_CHANGE |-> sel_wait <= SEL_DELAY_CYC
    ) else $error("new frequency later than 3.5 us");

    AST_FO16_WRAP: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && fo_rise && cnt16 == 4'hf |=> cnt16 == 4'h0
    ) else $error("divide by sixteen did not wrap");

    AST_FO16_HOLD: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && !fo_rise |=> cnt16 == $past(cnt16)
    ) else $error("divide by sixteen stepped without a rise");

    AST_REF_TOGGLE: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce |=> ref_clk_out != $past(ref_clk_out)
    ) else $error("reference output stalled");

    AST_QTR_PHASE: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && qcnt == 2'h2 |=> ref_quarter_out
    ) else $error("quarter reference out of phase");

    AST_QTR_LOW: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && qcnt == 2'h0 |=> !ref_quarter_out
    ) else $error("quarter reference high too early");

endmodule // pbdiv_top

// ==== verilog/pbdiv_map.svh ====
`ifndef PBDIV_MAP_SVH
`define PBDIV_MAP_SVH

// ----------------------------------------------------------------------
// Widths and table size
// ----------------------------------------------------------------------
`define PBDIV_SEL_W 5
`define PBDIV_DIV_W 19
`define PBDIV_ROM_DEPTH 32
`define PBDIV_PIN_W 7

// ----------------------------------------------------------------------
// Divider limits and ratios
// ----------------------------------------------------------------------
`define PBDIV_DIV_MIN 19'h00006
`define PBDIV_FO16_W 4
`define PBDIV_QTR_W 2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PBDIV_SEL_RST 5'h1f
`define PBDIV_DIV_RST 19'h00000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PBDIV_CLK_NS 50
`define PBDIV_SEL_DELAY_NS 3500
`define PBDIV_SEL_DELAY_CYC ((`PBDIV_SEL_DELAY_NS) / (`PBDIV_CLK_NS))

`endif

// ==== verilog/pbdiv_pkg.sv ====
package pbdiv_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic {
        PBDIV_PH_LOW = 1'b0,
        PBDIV_PH_HIGH = 1'b1
    } pbdiv_phase_t;

    typedef struct packed {
        logic [4:0] sel;
        logic gate;
        logic en;
    } pbdiv_pins_t;

endpackage

// ==== verilog/pbdiv_sync.sv ====
`timescale 1ns/1ps
`include "pbdiv_map.svh"

module pbdiv_sync
    import pbdiv_pkg::*;
#(
    parameter int W = `PBDIV_PIN_W,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // ------------------------------------------------------------------
    // Three stages, second and third must agree
    // ------------------------------------------------------------------
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    wire logic [W-1:0] agree = ~(s2 ^ s3);
    wire logic [W-1:0] next_q = (agree & s3) | (~agree & q);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
            q <= RST_VAL;
        end else if (ce) begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q <= next_q;
        end
    end

endmodule // pbdiv_sync

// ==== verilog/pbdiv_rom.sv ====
`timescale 1ns/1ps
`include "pbdiv_map.svh"

module pbdiv_rom
    import pbdiv_pkg::*;
(
    input wire logic clk,
    input wire logic ce,
    input wire logic [`PBDIV_SEL_W-1:0] addr,
    output logic [`PBDIV_DIV_W-1:0] data
);

    // ------------------------------------------------------------------
    // Divisor table, index bit 4 is the top select bit
    // ------------------------------------------------------------------
    logic [`PBDIV_DIV_W-1:0] rom [0:`PBDIV_ROM_DEPTH-1];

    always_comb begin
        rom[0] = 19'd731;
        rom[1] = 19'd733;
        rom[2] = 19'd735;
        rom[3] = 19'd737;
        rom[4] = 19'd741;
        rom[5] = 19'd743;
        rom[6] = 19'd745;
        rom[7] = 19'd751;
        rom[8] = 19'd6970;
        rom[9] = 19'd5569;
        rom[10] = 19'd5433;
        rom[11] = 19'd4752;
        rom[12] = 19'd4269;
        rom[13] = 19'd1920;
        rom[14] = 19'd1584;
        rom[15] = 19'd301;
        rom[16] = 19'd5760;
        rom[17] = 19'd3840;
        rom[18] = 19'd2618;
        rom[19] = 19'd2141;
        rom[20] = 19'd1920;
        rom[21] = 19'd960;
        rom[22] = 19'd480;
        rom[23] = 19'd240;
        rom[24] = 19'd160;
        rom[25] = 19'd144;
        rom[26] = 19'd120;
        rom[27] = 19'd80;
        rom[28] = 19'd60;
        rom[29] = 19'd40;
        rom[30] = 19'd30;
        rom[31] = 19'd15;
    end

    // Registered read keeps the divider path short
    always_ff @(posedge clk) begin
        if (ce) begin
            data <= rom[addr];
        end
    end

endmodule // pbdiv_rom

// ==== bench/pbdiv_serial_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Receiver side: measures the rate clocks it is fed
// ----------------------------------------------------------------------
module pbdiv_serial_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rate_clk,
    input wire logic baud_1x,
    output int rate_hi,
    output int rate_lo,
    output int x1_hi,
    output int x1_lo,
    output int rate_falls,
    output int x1_falls
);
    logic rate_q;
    logic x1_q;
    int rate_cnt;
    int x1_cnt;

    // Sampled on the reference edge, the only timebase a receiver has
    always @(posedge clk) begin
        if (!rst_n) begin
            rate_q <= 1'b1;
            x1_q <= 1'b1;
            rate_cnt <= 1;
            x1_cnt <= 1;
        end else begin
            rate_q <= rate_clk;
            x1_q <= baud_1x;
            if (rate_clk === rate_q) begin
                rate_cnt <= rate_cnt + 1;
            end else begin
                rate_cnt <= 1;
                if (rate_q) begin
                    rate_hi <= rate_cnt;
                    rate_falls <= rate_falls + 1;
                end else begin
                    rate_lo <= rate_cnt;
                end
            end
            if (baud_1x === x1_q) begin
                x1_cnt <= x1_cnt + 1;
            end else begin
                x1_cnt <= 1;
                if (x1_q) begin
                    x1_hi <= x1_cnt;
                    x1_falls <= x1_falls + 1;
                end else begin
                    x1_lo <= x1_cnt;
                end
            end
        end
    end
endmodule // pbdiv_serial_model

// ==== bench/programmable_baud_divider_tb.sv ====
`timescale 1ns/1ps
`include "pbdiv_map.svh"

`define CHK(nm, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("[FAIL] %s expected %0d seen %0d", nm, exp, got); \
        end \
    end

module programmable_baud_divider_tb
    import pbdiv_pkg::*;
;
    logic clk;
    logic rst_n;
    logic ce;
    pbdiv_pins_t pins;
    logic [4:0] sel_open;
    logic en_open;
    logic rate_clk_out, baud_1x_out, ref_clk_out, ref_quarter_out;
    int rate_hi, rate_lo, x1_hi, x1_lo, rate_falls, x1_falls;
    logic dly_rate, dly_1x;
    int dly_hi, dly_lo, dly_falls;
    int num_errors = 0;
    int checks_done = 0;

    // ------------------------------------------------------------------
    // Design, receiver and clock
    // ------------------------------------------------------------------
    pbdiv_top dut (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .sel_pins(pins.sel),
        .sel_pins_open(sel_open),
        .sel_latch_gate(pins.gate),
        .rate_output_enable_n(pins.en),
        .rate_enable_open(en_open),
        .rate_clk_out(rate_clk_out),
        .baud_1x_out(baud_1x_out),
        .ref_clk_out(ref_clk_out),
        .ref_quarter_out(ref_quarter_out)
    );

    pbdiv_serial_model uart (
        .clk(clk),
        .rst_n(rst_n),
        .rate_clk(rate_clk_out),
        .baud_1x(baud_1x_out),
        .rate_hi(rate_hi),
        .rate_lo(rate_lo),
        .x1_hi(x1_hi),
        .x1_lo(x1_lo),
        .rate_falls(rate_falls),
        .x1_falls(x1_falls)
    );

    // Second build with the deferred-change option
    pbdiv_top #(
        .IMMEDIATE_CHANGE(1'b0)
    ) dut_dly (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .sel_pins(pins.sel),
        .sel_pins_open(sel_open),
        .sel_latch_gate(pins.gate),
        .rate_output_enable_n(pins.en),
        .rate_enable_open(en_open),
        .rate_clk_out(dly_rate),
        .baud_1x_out(dly_1x),
        .ref_clk_out(),
        .ref_quarter_out()
    );

    pbdiv_serial_model uart_dly (
        .clk(clk),
        .rst_n(rst_n),
        .rate_clk(dly_rate),
        .baud_1x(dly_1x),
        .rate_hi(dly_hi),
        .rate_lo(dly_lo),
        .x1_hi(),
        .x1_lo(),
        .rate_falls(dly_falls),
        .x1_falls()
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Falls seen at 0 rate, 1 the 1X output, 2 deferred rate
    function automatic int falls_of(input int which);
        case (which)
            1: return x1_falls;
            2: return dly_falls;
            default: return rate_falls;
        endcase
    endfunction

    // Bounded: a stuck output must not hang the run
    task automatic wait_falls(input int n, input int which);
        int start;
        int k;
        start = falls_of(which);
        k = 0;
        while ((falls_of(which) - start) < n) begin
            @(negedge clk);
            k++;
            if (k > 40000) begin
                num_errors++;
                $display("[FAIL] edge_wait expected 0 seen %0d", k);
                final_report();
            end
        end
    endtask

    task automatic set_sel(input logic [4:0] v);
        @(negedge clk);
        pins.sel = v;
        sel_open = 5'h00;
    endtask

    // First full halves after the settle window must be the new divisor
    task automatic check_div(input int n);
        repeat (`PBDIV_SEL_DELAY_CYC) @(negedge clk);
        wait_falls(2, 0);
        `CHK("rate_high", (n + 1) / 2, rate_hi)
        `CHK("rate_low", n / 2, rate_lo)
        wait_falls(2, 2);
        `CHK("dly_high", (n + 1) / 2, dly_hi)
        `CHK("dly_low", n / 2, dly_lo)
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (8) @(negedge clk);
        `CHK("rst_rate", 1'b1, rate_clk_out)
        `CHK("rst_1x", 1'b1, baud_1x_out)
        `CHK("rst_ref", 1'b0, ref_clk_out)
        `CHK("rst_quarter", 1'b0, ref_quarter_out)
        rst_n = 1'b1;
        $display("test reset done");
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_table();
        logic [4:0] idx [8] = '{5'h1f, 5'h1e, 5'h1d, 5'h1b, 5'h17,
                                5'h0f, 5'h00, 5'h07};
        int div [8] = '{15, 30, 40, 80, 240, 301, 731, 751};
        for (int i = 0; i < 8; i++) begin
            set_sel(idx[i]);
            check_div(div[i]);
        end
        $display("test table done");
    endtask

    task automatic test_pullup();
        @(negedge clk);
        pins.sel = 5'h00;
        sel_open = 5'h1f;
        check_div(15);
        $display("test pullup done");
    endtask

    task automatic test_latch();
        set_sel(5'h1f);
        check_div(15);
        pins.gate = 1'b0;
        repeat (8) @(negedge clk);
        pins.sel = 5'h1e;
        repeat (100) @(negedge clk);
        check_div(15);
        pins.gate = 1'b1;
        check_div(30);
        $display("test latch done");
    endtask

    task automatic test_x1();
        wait_falls(3, 1);
        `CHK("x1_high", 240, x1_hi)
        `CHK("x1_low", 240, x1_lo)
        $display("test x1 done");
    endtask

    task automatic test_enable();
        int bad;
        bad = 0;
        @(negedge clk);
        pins.en = 1'b0;
        repeat (8) @(negedge clk);
        repeat (300) begin
            @(negedge clk);
            if (rate_clk_out !== 1'b1 || baud_1x_out !== 1'b1) bad++;
        end
        `CHK("enable_hold", 0, bad)
        en_open = 1'b1;
        repeat (8) @(negedge clk);
        wait_falls(2, 0);
        `CHK("open_enable_high", 15, rate_hi)
        en_open = 1'b0;
        pins.en = 1'b1;
        $display("test enable done");
    endtask

    // Clock enable low must hold every output where it stands
    task automatic test_freeze();
        logic [3:0] held;
        int moved;
        moved = 0;
        @(negedge clk);
        ce = 1'b0;
        @(negedge clk);
        held = {rate_clk_out, baud_1x_out, ref_clk_out, ref_quarter_out};
        repeat (40) begin
            @(negedge clk);
            if ({rate_clk_out, baud_1x_out, ref_clk_out,
                ref_quarter_out} !== held) moved++;
        end
        `CHK("freeze_hold", 0, moved)
        ce = 1'b1;
        wait_falls(2, 0);
        `CHK("freeze_resume", 15, rate_hi)
        $display("test freeze done");
    endtask

    task automatic test_ref();
        logic [7:0] f;
        logic [7:0] q;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            f[i] = ref_clk_out;
            q[i] = ref_quarter_out;
        end
        `CHK("quarter_duty", 2, $countones(q[3:0]))
        for (int i = 0; i < 6; i++) begin
            `CHK("ref_toggle", ~f[i], f[i + 1])
            `CHK("quarter_half", ~q[i], q[i + 2])
        end
        $display("test ref done");
    endtask

    initial begin
        rst_n = 1'b0;
        pins.sel = 5'h00;
        pins.gate = 1'b1;
        pins.en = 1'b1;
        sel_open = 5'h00;
        en_open = 1'b0;
        ce = 1'b1;
        do_reset();
        test_table();
        test_pullup();
        test_latch();
        test_x1();
        test_enable();
        test_freeze();
        test_ref();
        @(negedge clk);
        do_reset();
        final_report();
    end
endmodule // programmable_baud_divider_tb
